// ==== design/pfs_pkg.sv ====
// shared constants and types for the program flow sequencer
package pfs_pkg;
	localparam int PFS_PC_W = 11;
	localparam int PFS_DEPTH = 8;
	localparam logic [7:0] PFS_ADDR_PCL = 8'h02;
	localparam logic [7:0] PFS_ADDR_STATUS = 8'h03;
	localparam logic [7:0] PFS_ADDR_FSR = 8'h04;
	localparam int PFS_C = 0;
	localparam int PFS_DC = 1;
	localparam int PFS_Z = 2;
	localparam int PFS_PD = 3;
	localparam int PFS_TO = 4;
	localparam int PFS_PA_LO = 5;
	localparam int PFS_PA_HI = 6;
	localparam int PFS_PA_TOP = 7;
	localparam int PFS_BANK_LO = 5;
	localparam logic [10:0] PFS_PC_RESET = 11'h000;
	localparam logic [7:0] PFS_STATUS_RESET = 8'h18;
	localparam logic [7:0] PFS_FSR_RESET = 8'h00;
	localparam logic [7:0] PFS_W_RESET = 8'h00;
	localparam logic [7:0] PFS_ONE = 8'h01;
	localparam logic [10:0] PFS_PC_ONE = 11'h001;

	typedef enum logic [4:0] {
		PFS_OP_NOP, PFS_OP_JMP, PFS_OP_CALL, PFS_OP_PAGE, PFS_OP_BANK,
		PFS_OP_RET, PFS_OP_SUBROUTINE_EXIT_WITH_PAGE, PFS_OP_INTERRUPT_EXIT, PFS_OP_INTERRUPT_EXIT_ADD_ACC, PFS_OP_EXIT_LOAD_LITERAL,
		PFS_OP_DECREMENT_SKIP_ZERO, PFS_OP_INCSZ, PFS_OP_SKIP_CLR, PFS_OP_SKIP_SET,
		PFS_OP_BIT_CLR, PFS_OP_BIT_SET, PFS_OP_AND, PFS_OP_OR, PFS_OP_XOR,
		PFS_OP_RL, PFS_OP_RR, PFS_OP_NOT, PFS_OP_NOT_W, PFS_OP_SWAP_W
	} pfs_op_e;

	typedef logic [10:0] pfs_pc_t;
endpackage

// ==== design/pfs_sequencer.sv ====
// program flow sequencer: pc, return stack, skips and small alu
`timescale 1ns/10ps
module pfs_sequencer
	import pfs_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// decoded instruction
	input wire logic instr_valid,
	input wire pfs_op_e instr_op,
	input wire logic [8:0] instr_addr,
	input wire logic [7:0] instr_lit,
	input wire logic [7:0] instr_faddr,
	input wire logic [2:0] instr_bit,
	input wire logic instr_to_file,
	output logic instr_ready,
	output logic skipping,
	// file operand from data memory
	input wire logic [7:0] file_rdata,
	output logic file_we,
	output logic [7:0] file_waddr,
	output logic [7:0] file_wdata,
	// core state
	output logic [10:0] program_counter,
	output logic [7:0] status_flags,
	output logic [7:0] indirect_file_pointer,
	output logic [7:0] work_acc,
	// realtime counter add request
	output logic realtime_add,
	output logic [7:0] realtime_delta
);
	logic rst_meta_reg;
	logic rst_n;
	pfs_pc_t pc_reg;
	pfs_pc_t pc_next;
	pfs_pc_t stack_reg [1:PFS_DEPTH];
	logic [7:0] status_reg;
	logic [7:0] fsr_reg;
	logic [7:0] w_reg;
	logic ready_reg;
	logic skip_reg;
	logic we_reg;
	logic [7:0] waddr_reg;
	logic [7:0] wdata_reg;
	logic rtc_reg;
	logic [7:0] rtc_delta_reg;
	logic take;
	logic exec;
	logic consume;
	logic [7:0] operand;
	logic [7:0] res;
	logic res_c;
	logic wr_file;
	logic wr_w;
	logic set_z;
	logic skip_cond;
	logic do_push;
	logic do_pop;
	logic bubble;
	logic [1:0] pa;

	// async assert, release through two stages
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	function automatic logic is_page_bank(input pfs_op_e op);
		return (op == PFS_OP_PAGE) || (op == PFS_OP_BANK);
	endfunction

	function automatic logic is_return(input pfs_op_e op);
		return (op == PFS_OP_RET) || (op == PFS_OP_SUBROUTINE_EXIT_WITH_PAGE) ||
			(op == PFS_OP_INTERRUPT_EXIT) || (op == PFS_OP_INTERRUPT_EXIT_ADD_ACC) ||
			(op == PFS_OP_EXIT_LOAD_LITERAL);
	endfunction

	assign take = clk_en && instr_valid && ready_reg;
	assign exec = take && !skip_reg;
	assign consume = take && skip_reg;
	assign pa = status_reg[PFS_PA_HI:PFS_PA_LO];

	// mapped core registers shadow the memory operand
	always_comb begin
		unique case (instr_faddr)
			PFS_ADDR_PCL: operand = pc_reg[7:0];
			PFS_ADDR_STATUS: operand = status_reg;
			PFS_ADDR_FSR: operand = fsr_reg;
			default: operand = file_rdata;
		endcase
	end

	always_comb begin
		res = operand;
		res_c = status_reg[PFS_C];
		wr_file = 1'b0;
		wr_w = 1'b0;
		set_z = 1'b0;
		skip_cond = 1'b0;
		unique case (instr_op)
			PFS_OP_AND, PFS_OP_OR, PFS_OP_XOR: begin
				if (instr_op == PFS_OP_AND) begin
					res = w_reg & operand;
				end else if (instr_op == PFS_OP_OR) begin
					res = w_reg | operand;
				end else begin
					res = w_reg ^ operand;
				end
				wr_file = instr_to_file;
				wr_w = !instr_to_file;
				set_z = 1'b1;
			end
			PFS_OP_RL, PFS_OP_RR: begin
				if (instr_op == PFS_OP_RL) begin
					res = {operand[6:0], status_reg[PFS_C]};
					res_c = operand[7];
				end else begin
					res = {status_reg[PFS_C], operand[7:1]};
					res_c = operand[0];
				end
				wr_file = instr_to_file;
				wr_w = !instr_to_file;
			end
			PFS_OP_NOT: begin
				res = ~operand;
				wr_file = instr_to_file;
				wr_w = !instr_to_file;
				set_z = 1'b1;
			end
			PFS_OP_NOT_W: begin
				res = ~w_reg;
				wr_w = 1'b1;
				set_z = 1'b1;
			end
			PFS_OP_SWAP_W: begin
				res = {operand[3:0], operand[7:4]};
				wr_w = 1'b1;
			end
			PFS_OP_DECREMENT_SKIP_ZERO, PFS_OP_INCSZ: begin
				if (instr_op == PFS_OP_DECREMENT_SKIP_ZERO) begin
					res = operand - PFS_ONE;
				end else begin
					res = operand + PFS_ONE;
				end
				wr_file = 1'b1;
				skip_cond = (res == 8'h00);
			end
			PFS_OP_SKIP_CLR: skip_cond = !operand[instr_bit];
			PFS_OP_SKIP_SET: skip_cond = operand[instr_bit];
			PFS_OP_BIT_CLR: begin
				res = operand & ~(PFS_ONE << instr_bit);
				wr_file = 1'b1;
			end
			PFS_OP_BIT_SET: begin
				res = operand | (PFS_ONE << instr_bit);
				wr_file = 1'b1;
			end
			default: ;
		endcase
	end

	// next pc and pipeline refill
	always_comb begin
		pc_next = pc_reg;
		do_push = 1'b0;
		do_pop = 1'b0;
		bubble = 1'b0;
		if (consume) begin
			pc_next = pc_reg + PFS_PC_ONE;
		end else if (exec) begin
			pc_next = pc_reg + PFS_PC_ONE;
			if (instr_op == PFS_OP_JMP) begin
				pc_next = {pa, instr_addr};
				bubble = 1'b1;
			end else if (instr_op == PFS_OP_CALL) begin
				pc_next = {pa, 1'b0, instr_addr[7:0]};
				do_push = 1'b1;
				bubble = 1'b1;
			end else if (is_return(instr_op)) begin
				pc_next = stack_reg[1];
				do_pop = 1'b1;
				bubble = 1'b1;
			end else if (wr_file && instr_faddr == PFS_ADDR_PCL) begin
				// computed jump within the current 256-word block
				pc_next = {pc_reg[10:8], res};
				bubble = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= PFS_PC_RESET;
			ready_reg <= 1'b0;
		end else if (clk_en) begin
			pc_reg <= pc_next;
			ready_reg <= !bubble;
		end
	end

	// skip state: held across page/bank ops, so each costs a cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_reg <= 1'b0;
		end else if (exec) begin
			skip_reg <= skip_cond;
		end else if (consume) begin
			skip_reg <= is_page_bank(instr_op);
		end
	end

	// return stack, eleven bits per level
	generate
		for (genvar i = 1; i <= PFS_DEPTH; i++) begin : g_lvl
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					stack_reg[i] <= PFS_PC_RESET;
				end else if (do_push) begin
					if (i == 1) begin
						stack_reg[i] <= pc_reg + PFS_PC_ONE;
					end else begin
						stack_reg[i] <= stack_reg[i - 1];
					end
				end else if (do_pop && i < PFS_DEPTH) begin
					stack_reg[i] <= stack_reg[i + 1];
				end
			end
		end
	endgenerate

	// powerdown and timeout are not writable by instructions
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= PFS_STATUS_RESET;
		end else if (exec) begin
			if (instr_op == PFS_OP_PAGE) begin
				status_reg[PFS_PA_HI:PFS_PA_LO] <= instr_lit[1:0];
			end else if (instr_op == PFS_OP_SUBROUTINE_EXIT_WITH_PAGE) begin
				status_reg[PFS_PA_HI:PFS_PA_LO] <= stack_reg[1][10:9];
			end else begin
				if (wr_file && instr_faddr == PFS_ADDR_STATUS) begin
					status_reg[PFS_PA_TOP:PFS_PA_LO] <= res[7:5];
					status_reg[PFS_DC] <= res[PFS_DC];
					status_reg[PFS_C] <= res[PFS_C];
					status_reg[PFS_Z] <= res[PFS_Z];
				end
				if (set_z) begin
					status_reg[PFS_Z] <= (res == 8'h00);
				end
				if (instr_op == PFS_OP_RL || instr_op == PFS_OP_RR) begin
					status_reg[PFS_C] <= res_c;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fsr_reg <= PFS_FSR_RESET;
		end else if (exec) begin
			if (instr_op == PFS_OP_BANK) begin
				fsr_reg[7:PFS_BANK_LO] <= instr_lit[7:PFS_BANK_LO];
			end else if (wr_file && instr_faddr == PFS_ADDR_FSR) begin
				fsr_reg <= res;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_reg <= PFS_W_RESET;
		end else if (exec) begin
			if (instr_op == PFS_OP_EXIT_LOAD_LITERAL) begin
				w_reg <= instr_lit;
			end else if (wr_w) begin
				w_reg <= res;
			end
		end
	end

	// plain memory write and realtime counter requests, one-cycle pulses
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			we_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			rtc_reg <= 1'b0;
			rtc_delta_reg <= 8'h00;
		end else if (clk_en) begin
			we_reg <= exec && wr_file && instr_faddr != PFS_ADDR_PCL &&
				instr_faddr != PFS_ADDR_STATUS && instr_faddr != PFS_ADDR_FSR;
			waddr_reg <= instr_faddr;
			wdata_reg <= res;
			rtc_reg <= exec && instr_op == PFS_OP_INTERRUPT_EXIT_ADD_ACC;
			rtc_delta_reg <= w_reg;
		end
	end

	assign instr_ready = ready_reg;
	assign skipping = skip_reg;
	assign file_we = we_reg;
	assign file_waddr = waddr_reg;
	assign file_wdata = wdata_reg;
	assign program_counter = pc_reg;
	assign status_flags = status_reg;
	assign indirect_file_pointer = fsr_reg;
	assign work_acc = w_reg;
	assign realtime_add = rtc_reg;
	assign realtime_delta = rtc_delta_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_jmp;
		exec && instr_op == PFS_OP_JMP |=>
			pc_reg == {$past(pa), $past(instr_addr)};
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump target wrong");

	property p_call;
		exec && instr_op == PFS_OP_CALL |=>
			pc_reg[8] == 1'b0 && pc_reg[7:0] == $past(instr_addr[7:0]) &&
			pc_reg[10:9] == $past(pa) &&
			stack_reg[1] == $past(pc_reg) + PFS_PC_ONE;
	endproperty
	a_call: assert property (p_call) else $error("call wrong");

	property p_push_shift;
		exec && instr_op == PFS_OP_CALL |=>
			stack_reg[8] == $past(stack_reg[7]);
	endproperty
	a_push_shift: assert property (p_push_shift) else $error("push");

	property p_pop;
		exec && is_return(instr_op) |=>
			pc_reg == $past(stack_reg[1]) && stack_reg[7] == stack_reg[8];
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");

	property p_page;
		exec && instr_op == PFS_OP_PAGE |=> pa == $past(instr_lit[1:0]) &&
			ready_reg;
	endproperty
	a_page: assert property (p_page) else $error("page op wrong");

	property p_refill;
		exec && instr_op == PFS_OP_JMP && clk_en |=> !ready_reg ##1 ready_reg;
	endproperty
	a_refill: assert property (p_refill) else $error("refill");

	property p_skip;
		exec && skip_cond |=> skip_reg;
	endproperty
	a_skip: assert property (p_skip) else $error("skip lost");

	property p_skip_chain;
		consume |=> skip_reg == $past(is_page_bank(instr_op)) &&
			pc_reg == $past(pc_reg) + PFS_PC_ONE;
	endproperty
	a_skip_chain: assert property (p_skip_chain) else $error("chain");

	property p_exit_load_literal;
		exec && instr_op == PFS_OP_EXIT_LOAD_LITERAL |=> w_reg == $past(instr_lit);
	endproperty
	a_exit_load_literal: assert property (p_exit_load_literal) else $error("literal return");

	property p_seq;
		exec && instr_op == PFS_OP_NOP |=> pc_reg == $past(pc_reg) + PFS_PC_ONE;
	endproperty
	a_seq: assert property (p_seq) else $error("pc advance");

	c_call_ret: cover property (exec && instr_op == PFS_OP_CALL ##[2:20]
		exec && instr_op == PFS_OP_RET);
	c_skip_page: cover property (exec && skip_cond ##1
		consume && instr_op == PFS_OP_PAGE ##1 consume);
	c_interrupt_exit_add_acc: cover property (exec && instr_op == PFS_OP_INTERRUPT_EXIT_ADD_ACC);
endmodule

// ==== testbench/pfs_testbench.sv ====
// self-checking random bench for the program flow sequencer
`timescale 1ns/10ps
module testbench
	import pfs_pkg::*;
;
	logic core_clk, nrst, clk_en, instr_valid, instr_to_file;
	pfs_op_e instr_op;
	logic [8:0] instr_addr;
	logic [7:0] instr_lit, instr_faddr, file_rdata;
	logic [2:0] instr_bit;
	logic instr_ready, skipping, file_we, realtime_add;
	logic [7:0] file_waddr, file_wdata, status_flags, realtime_delta;
	logic [7:0] indirect_file_pointer, work_acc, w_exp, f;
	logic [10:0] program_counter, pc_exp;
	logic [10:0] stk [8];
	logic [1:0] pa_exp;
	logic dest, c_exp;
	logic [31:0] seed, r;
	int n_mismatch, checks;
	pfs_op_e rops [4] = '{PFS_OP_EXIT_LOAD_LITERAL, PFS_OP_INTERRUPT_EXIT_ADD_ACC, PFS_OP_SUBROUTINE_EXIT_WITH_PAGE, PFS_OP_INTERRUPT_EXIT};
	pfs_op_e lops [4] = '{PFS_OP_AND, PFS_OP_OR, PFS_OP_XOR, PFS_OP_AND};

	pfs_sequencer i_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr_op(instr_op),
		.instr_addr(instr_addr), .instr_lit(instr_lit),
		.instr_faddr(instr_faddr), .instr_bit(instr_bit),
		.instr_to_file(instr_to_file), .instr_ready(instr_ready),
		.skipping(skipping), .file_rdata(file_rdata), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata),
		.program_counter(program_counter), .status_flags(status_flags),
		.indirect_file_pointer(indirect_file_pointer),
		.work_acc(work_acc), .realtime_add(realtime_add),
		.realtime_delta(realtime_delta));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] alu(pfs_op_e op, logic [7:0] w,
		logic [7:0] v);
		case (op)
			PFS_OP_AND: return w & v;
			PFS_OP_OR: return w | v;
			default: return w ^ v;
		endcase
	endfunction

	task automatic push(logic [10:0] v);
		for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
		stk[0] = v;
	endtask

	// level 8 is kept, so it ends up duplicated in level 7
	task automatic pop();
		pc_exp = stk[0];
		for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
	endtask

	task automatic chk(string name, logic [10:0] seen, logic [10:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// holds the request until ready is seen high, results read mid-cycle
	task automatic issue(pfs_op_e op, logic [8:0] a, logic [7:0] l,
		logic [7:0] fa, logic [2:0] b, logic [7:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		instr_op <= op;
		instr_addr <= a;
		instr_lit <= l;
		instr_faddr <= fa;
		instr_bit <= b;
		file_rdata <= rd;
		instr_to_file <= dest;
		instr_valid <= 1'b1;
		@(negedge core_clk);
		while (instr_ready !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		chk("instr_ready", instr_ready, 11'h001);
		@(posedge core_clk);
		instr_valid <= 1'b0;
		@(negedge core_clk);
	endtask

	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		instr_valid = 1'b0;
		instr_op = PFS_OP_NOP;
		instr_addr = 9'h000;
		instr_lit = 8'h00;
		instr_faddr = 8'h10;
		instr_bit = 3'h0;
		instr_to_file = 1'b0;
		file_rdata = 8'h00;
		seed = 32'd73585;
		n_mismatch = 0;
		checks = 0;
		pc_exp = PFS_PC_RESET;
		w_exp = PFS_W_RESET;
		pa_exp = 2'h0;
		dest = 1'b0;
		c_exp = PFS_STATUS_RESET[PFS_C];
		for (int i = 0; i < 8; i++) stk[i] = 11'h000;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(negedge core_clk);
		chk("status", status_flags, PFS_STATUS_RESET);
		for (int p = 0; p < 4; p++) begin
			r = rnd();
			issue(PFS_OP_PAGE, 9'h000, {r[7:2], p[1:0]}, 8'h10, 3'h0, 8'h00);
			pc_exp++;
			chk("page", status_flags[6:5], p[1:0]);
			chk("ready", instr_ready, 11'h001);
			chk("pc", program_counter, pc_exp);
			issue(PFS_OP_JMP, r[16:8], 8'h00, 8'h10, 3'h0, 8'h00);
			pc_exp = {p[1:0], r[16:8]};
			chk("jmp", program_counter, pc_exp);
			chk("refill", instr_ready, 11'h000);
		end
		pa_exp = 2'h3;
		// one call past the stack depth loses the oldest entry
		for (int i = 0; i < 9; i++) begin
			r = rnd();
			push(pc_exp + PFS_PC_ONE);
			issue(PFS_OP_CALL, r[8:0], 8'h00, 8'h10, 3'h0, 8'h00);
			pc_exp = {pa_exp, 1'b0, r[7:0]};
			chk("call", program_counter, pc_exp);
		end
		for (int i = 0; i < 9; i++) begin
			issue(PFS_OP_RET, 9'h000, 8'h00, 8'h10, 3'h0, 8'h00);
			pop();
			chk("ret", program_counter, pc_exp);
			chk("w", work_acc, w_exp);
		end
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			issue(PFS_OP_PAGE, 9'h000, r[31:24], 8'h10, 3'h0, 8'h00);
			pc_exp++;
			pa_exp = r[25:24];
			push(pc_exp + PFS_PC_ONE);
			issue(PFS_OP_CALL, r[8:0], 8'h00, 8'h10, 3'h0, 8'h00);
			issue(rops[k], 9'h000, r[23:16], 8'h10, 3'h0, 8'h00);
			if (rops[k] == PFS_OP_SUBROUTINE_EXIT_WITH_PAGE) pa_exp = stk[0][10:9];
			if (rops[k] == PFS_OP_INTERRUPT_EXIT_ADD_ACC) begin
				chk("rt_add", realtime_add, 11'h001);
				chk("rt_delta", realtime_delta, w_exp);
			end else begin
				chk("rt_add", realtime_add, 11'h000);
			end
			if (rops[k] == PFS_OP_EXIT_LOAD_LITERAL) w_exp = r[23:16];
			pop();
			chk("retx", program_counter, pc_exp);
			chk("retx_pa", status_flags[6:5], pa_exp);
			chk("retx_w", work_acc, w_exp);
		end
		// the last pass forces a zero result to see the flag set
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			f = (k == 3) ? ~w_exp : r[15:8];
			issue(lops[k], 9'h000, 8'h00, {4'h1, r[3:0]}, 3'h0, f);
			w_exp = alu(lops[k], w_exp, f);
			pc_exp++;
			chk("logic_w", work_acc, w_exp);
			chk("logic_z", status_flags[PFS_Z], w_exp == 8'h00);
		end
		issue(PFS_OP_NOT_W, 9'h000, 8'h00, 8'h10, 3'h0, 8'h00);
		w_exp = ~w_exp;
		pc_exp++;
		chk("not_w", work_acc, w_exp);
		issue(PFS_OP_DECREMENT_SKIP_ZERO, 9'h000, 8'h00, 8'h12, 3'h0, 8'h01);
		pc_exp++;
		chk("skip", skipping, 11'h001);
		chk("we", file_we, 11'h001);
		chk("wdata", file_wdata, 11'h000);
		chk("waddr", file_waddr, 11'h012);
		issue(PFS_OP_PAGE, 9'h000, 8'h00, 8'h10, 3'h0, 8'h00);
		pc_exp++;
		chk("skip", skipping, 11'h001);
		chk("pa", status_flags[6:5], pa_exp);
		issue(PFS_OP_BANK, 9'h000, 8'he0, 8'h10, 3'h0, 8'h00);
		pc_exp++;
		chk("skip", skipping, 11'h001);
		chk("fsr", indirect_file_pointer, PFS_FSR_RESET);
		issue(PFS_OP_JMP, 9'h155, 8'h00, 8'h10, 3'h0, 8'h00);
		pc_exp++;
		chk("skipped", program_counter, pc_exp);
		chk("skip", skipping, 11'h000);
		issue(PFS_OP_INCSZ, 9'h000, 8'h00, 8'h13, 3'h0, 8'h00);
		pc_exp++;
		chk("noskip", skipping, 11'h000);
		chk("wdata", file_wdata, 11'h001);
		for (int b = 0; b < 8; b++) begin
			r = rnd();
			f = r[7:0] | (8'h01 << b);
			issue(PFS_OP_SKIP_SET, 9'h000, 8'h00, 8'h14, b[2:0], f);
			chk("bit_set", skipping, 11'h001);
			issue(PFS_OP_NOP, 9'h000, 8'h00, 8'h10, 3'h0, 8'h00);
			chk("bit_set", skipping, 11'h000);
			issue(PFS_OP_SKIP_CLR, 9'h000, 8'h00, 8'h14, b[2:0], f);
			chk("bit_clr", skipping, 11'h000);
			pc_exp = pc_exp + 11'h003;
		end
		chk("pc", program_counter, pc_exp);
		// rotates through carry, complement, bit clear and swap
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			f = r[7:0];
			dest = 1'b1;
			issue(PFS_OP_RL, 9'h000, 8'h00, 8'h15, 3'h0, f);
			chk("rl", file_wdata, {f[6:0], c_exp});
			c_exp = f[7];
			chk("rl_c", status_flags[PFS_C], c_exp);
			issue(PFS_OP_NOT, 9'h000, 8'h00, 8'h16, 3'h0, f);
			chk("not", file_wdata, 8'(~f));
			chk("not_we", file_we, 11'h001);
			issue(PFS_OP_BIT_CLR, 9'h000, 8'h00, 8'h17, r[12:10], f);
			chk("bclr", file_wdata, 8'(f & ~(8'h01 << r[12:10])));
			dest = 1'b0;
			issue(PFS_OP_RR, 9'h000, 8'h00, 8'h15, 3'h0, f);
			w_exp = {c_exp, f[7:1]};
			c_exp = f[0];
			chk("rr", work_acc, w_exp);
			chk("rr_c", status_flags[PFS_C], c_exp);
			issue(PFS_OP_SWAP_W, 9'h000, 8'h00, 8'h16, 3'h0, f);
			w_exp = {f[3:0], f[7:4]};
			chk("swap", work_acc, w_exp);
			pc_exp = pc_exp + 11'h005;
		end
		// mapped core registers shadow the memory operand
		dest = 1'b1;
		issue(PFS_OP_BANK, 9'h000, 8'ha0, 8'h10, 3'h0, 8'h00);
		pc_exp++;
		chk("bank", indirect_file_pointer, 11'h0a0);
		issue(PFS_OP_BIT_SET, 9'h000, 8'h00, PFS_ADDR_FSR, 3'h1, 8'hff);
		pc_exp++;
		chk("fsr", indirect_file_pointer, 11'h0a2);
		chk("fsr_we", file_we, 11'h000);
		issue(PFS_OP_BIT_CLR, 9'h000, 8'h00, PFS_ADDR_STATUS, 3'h4, 8'h00);
		pc_exp++;
		chk("st_pdto", status_flags[4:3], 11'h003);
		chk("st_pa", status_flags[6:5], pa_exp);
		chk("st_c", status_flags[PFS_C], c_exp);
		issue(PFS_OP_BIT_SET, 9'h000, 8'h00, PFS_ADDR_STATUS, 3'h7, 8'h00);
		pc_exp++;
		chk("st_top", status_flags[7], 11'h001);
		issue(PFS_OP_BIT_SET, 9'h000, 8'h00, PFS_ADDR_PCL, 3'h7, 8'h00);
		pc_exp = {pc_exp[10:8], pc_exp[7:0] | 8'h80};
		chk("pcl", program_counter, pc_exp);
		chk("pcl_ready", instr_ready, 11'h000);
		tally_and_finish();
	end
endmodule
